// >>> cth_top.sv
// Cyclic timer and hardware option registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - On-time 000 stops timer, output low; 110 stops, output high; 111 reserved.
// RULE2 - On-time codes 001 to 101 give 0.1, 0.3, 1, 10, 20 ms pulses.
// RULE3 - Period code selects 10 ms up to 1000 s cycle length.
// RULE4 - Period code 0110 is taken as 1 s.
// RULE5 - Reserved bits read zero and ignore writes.
// RULE6 - Timer runs once assigned and a running on-time is written.
// RULE7 - Restart with timed high-side pin deselected clears period and on-time.
// RULE8 - Failures without restart leave timer settings untouched.
// RULE9 - Cyclic wake and cyclic sense share one running timer.
// RULE10 - New timer setting restarts the timer at once when the write ends.
// RULE11 - Timer register is zero after power-on, soft reset and restart.
// RULE12 - Hysteresis bit picks default or highest release threshold.
// RULE13 - Thermal release wait bit; zero means always 1 s.
// RULE14 - Reset delay bit: zero long delay, one short delay.
// RULE15 - Level-0 lock freezes pump enable and pin configuration.
// RULE16 - Soft reset clears bits 7 and 5:4; restart keeps the others.
// RULE17 - Level-1 lock freezes lockable bits until power-up.
// RULE18 - Level-1 lock takes hold only after its own write completes.
// RULE19 - Soft reset keeps bits protected by a set lock.
// RULE20 - Pin code 011 drives the pin from the cyclic timer.
module cth_top #(
    parameter int TICK_CYCLES = cth_pkg::TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cth_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [cth_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic soft_reset,
    input wire logic restart_mode,
    output logic timed_high_side_out,
    output logic cyclic_wake_tick,
    output logic uv_release_hyst_sel,
    output logic thermal_release_wait_sel,
    output logic reset_delay_sel,
    output logic pump_output_enable,
    output logic [2:0] pin_config
);
    import cth_pkg::*;

    // ********************
    // Bus slave
    // ********************
    logic aw_full, next_aw_full, w_full, next_w_full, w_en, next_w_en;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr, rd_addr;
    logic [7:0] w_data, next_w_data;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid, wr_do, rd_do, wr_hit, rd_hit, rd_timer;
    logic [31:0] next_rdata;
    logic [6:0] timer_reg, next_timer_reg;
    logic hyst, twait, rdel, lock0, lock1, pump, wake_en, kick, restart_q;
    logic next_hyst, next_twait, next_rdel, next_lock0, next_lock1;
    logic next_pump, next_wake_en, next_kick, next_restart_q;
    logic [2:0] pin, next_pin;
    logic run, next_out, next_wake;
    cth_cnt_t per_cnt, next_per_cnt;
    logic [15:0] div_cnt, next_div_cnt;

    assign awready = !aw_full;
    assign wready = !w_full;
    assign arready = !rvalid;
    assign wr_do = aw_full && w_full && !bvalid;
    assign rd_do = arvalid && !rvalid;
    assign rd_addr = araddr;
    assign rd_timer = rd_do && rd_addr == OFF_TIMER;
    assign wr_hit = aw_addr == OFF_TIMER || aw_addr == OFF_HWOPT || aw_addr == OFF_PINCFG
        || aw_addr == OFF_LOCK1 || aw_addr == OFF_STATUS;

    always_comb begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_en = w_en;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        rd_hit = 1'b1;
        if (awvalid && !aw_full) begin
            next_aw_full = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && !w_full) begin
            next_w_full = 1'b1;
            next_w_data = wdata[7:0];
            next_w_en = wstrb[0];
        end
        if (wr_do) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        case (rd_addr)
            // RULE5 reserved read zero.
            OFF_TIMER: next_rdata = {25'h0, timer_reg};
            OFF_HWOPT: next_rdata = {24'h0, hyst, 1'b0, twait, rdel, lock0, 3'h0};
            OFF_PINCFG: next_rdata = {26'h0, wake_en, pump, 1'b0, pin};
            OFF_LOCK1: next_rdata = {31'h0, lock1};
            OFF_STATUS: next_rdata = {29'h0, lock1, timed_high_side_out, run};
            default: begin
                next_rdata = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
        if (rd_do) begin
            next_rvalid = 1'b1;
            next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else begin
            next_rdata = rdata;
            if (rvalid && rready) begin
                next_rvalid = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
            w_full <= 1'b0;
            w_data <= 8'h00;
            w_en <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0;
        end else begin
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_en <= next_w_en;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // ********************
    // Configuration
    // ********************
    // A completed bus write stands for the frame end: values apply at that edge.
    always_comb begin
        next_timer_reg = timer_reg;
        next_hyst = hyst;
        next_twait = twait;
        next_rdel = rdel;
        next_lock0 = lock0;
        next_lock1 = lock1;
        next_pin = pin;
        next_pump = pump;
        next_wake_en = wake_en;
        next_kick = 1'b0;
        next_restart_q = restart_mode;
        if (wr_do && w_en) begin
            case (aw_addr)
                OFF_TIMER: begin
                    // RULE10 apply at once.
                    next_timer_reg = w_data[6:0];
                    next_kick = 1'b1;
                end
                OFF_HWOPT: begin
                    // RULE17 level-1 lock blocks.
                    if (!lock1) begin
                        next_hyst = w_data[HYST_BIT];
                        next_twait = w_data[TWAIT_BIT];
                        next_rdel = w_data[RDEL_BIT];
                    end
                    // RULE15 lock bit plain.
                    next_lock0 = w_data[LOCK0_BIT];
                end
                OFF_PINCFG: begin
                    // RULE15 level-0 lock blocks.
                    if (!lock0) begin
                        next_pin = w_data[2:0];
                        next_pump = w_data[PUMP_BIT];
                    end
                    next_wake_en = w_data[WAKE_BIT];
                end
                // RULE18 lock holds after write.
                OFF_LOCK1: next_lock1 = lock1 | w_data[0];
                default: next_lock1 = lock1;
            endcase
        end
        // RULE19 locked bits survive.
        if (soft_reset) begin
            next_timer_reg = TIMER_RST;
            next_wake_en = 1'b0;
            next_kick = 1'b1;
            if (!lock1) begin
                next_hyst = 1'b0;
                next_twait = 1'b0;
                next_rdel = 1'b0;
            end
            if (!lock0) begin
                next_pin = PIN_RST;
                next_pump = 1'b0;
            end
        end
        // RULE11 restart entry clears.
        if (restart_mode && !restart_q) begin
            next_timer_reg = TIMER_RST;
            next_kick = 1'b1;
        end
        // RULE7 sense pin dropped.
        if (restart_mode && pin != PIN_HS_TIMER) begin
            next_timer_reg = TIMER_RST;
        end
    end

    // RULE16 reset values.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_reg <= TIMER_RST;
            hyst <= 1'b0;
            twait <= 1'b0;
            rdel <= 1'b0;
            lock0 <= 1'b0;
            lock1 <= 1'b0;
            pin <= PIN_RST;
            pump <= 1'b0;
            wake_en <= 1'b0;
            kick <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            timer_reg <= next_timer_reg;
            hyst <= next_hyst;
            twait <= next_twait;
            rdel <= next_rdel;
            lock0 <= next_lock0;
            lock1 <= next_lock1;
            pin <= next_pin;
            pump <= next_pump;
            wake_en <= next_wake_en;
            kick <= next_kick;
            restart_q <= next_restart_q;
        end
    end

    // RULE12 hysteresis select.
    assign uv_release_hyst_sel = hyst;
    // RULE13 thermal wait select.
    assign thermal_release_wait_sel = twait;
    // RULE14 reset delay select.
    assign reset_delay_sel = rdel;
    assign pump_output_enable = pump;
    assign pin_config = pin;

    // ********************
    // Cyclic timer
    // ********************
    // RULE6 assigned and running.
    assign run = (pin == PIN_HS_TIMER || wake_en) && timer_reg[6:4] != ON_OFF_LOW
        && timer_reg[6:4] <= ON_MAX_RUN;

    // RULE8 only aresetn, restart or soft reset clear settings.
    always_comb begin
        next_div_cnt = div_cnt;
        next_per_cnt = per_cnt;
        next_wake = 1'b0;
        if (kick || !run) begin
            next_div_cnt = 16'h0;
            next_per_cnt = '0;
        end else if (div_cnt == 16'(TICK_CYCLES - 1)) begin
            next_div_cnt = 16'h0;
            // RULE3 period wrap.
            if (per_cnt >= cth_per_ticks(timer_reg[3:0]) - 24'h1) begin
                next_per_cnt = '0;
                // RULE9 wake shares timer.
                next_wake = wake_en;
            end else begin
                next_per_cnt = per_cnt + 24'h1;
            end
        end else begin
            next_div_cnt = div_cnt + 16'h1;
        end
        // RULE2 pulse length.
        if (run) begin
            next_out = next_per_cnt < cth_on_ticks(timer_reg[6:4]);
        end else begin
            // RULE1 stopped levels.
            next_out = timer_reg[6:4] == ON_OFF_HIGH;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 16'h0;
            per_cnt <= '0;
            timed_high_side_out <= 1'b0;
            cyclic_wake_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            per_cnt <= next_per_cnt;
            // RULE20 pin follows timer.
            timed_high_side_out <= next_out;
            cyclic_wake_tick <= next_wake;
        end
    end

    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_off_low_level: assert property (timer_reg[6:4] == ON_OFF_LOW |=> !timed_high_side_out)
        else $error("Output not low for on-time zero."); // RULE1
    a_off_high_level: assert property (timer_reg[6:4] == ON_OFF_HIGH |=> timed_high_side_out)
        else $error("Output not high for on-time 110."); // RULE1
    a_on_window: assert property (run && !kick && timed_high_side_out
        |-> per_cnt < cth_on_ticks(timer_reg[6:4]))
        else $error("Output high outside on-time."); // RULE2
    a_period_bound: assert property (run && !kick |-> per_cnt < cth_per_ticks(timer_reg[3:0]))
        else $error("Period count beyond period."); // RULE3
    a_reserved_zero: assert property (rd_timer |=> rdata[31:7] == 25'h0)
        else $error("Reserved timer bits read nonzero."); // RULE5
    a_kick_restart: assert property (kick |=> per_cnt == '0 && div_cnt == 16'h0)
        else $error("Timer not restarted on new setting."); // RULE10
    a_restart_clear: assert property ($rose(restart_mode) |=> timer_reg == TIMER_RST)
        else $error("Timer not cleared on restart."); // RULE11
    a_sense_clear: assert property (restart_mode && pin != PIN_HS_TIMER |=> timer_reg == TIMER_RST)
        else $error("Timer kept with sense pin deselected."); // RULE7
    a_lock1_hold: assert property (lock1 |=> $stable({hyst, twait, rdel, lock1}))
        else $error("Level-1 locked bits changed."); // RULE17
    a_lock0_hold: assert property (lock0 |=> $stable({pin, pump}))
        else $error("Level-0 locked bits changed."); // RULE15

    c_wake_tick: cover property (cyclic_wake_tick && timed_high_side_out);
    c_lock1_set: cover property ($rose(lock1));
    c_write_read: cover property (bvalid ##[1:8] rvalid);
endmodule : cth_top
`default_nettype wire

// >>> cth_pkg.sv
// Constants shared by the cyclic timer and hardware option block.
package cth_pkg;
    localparam int ADDR_W = 8;
    // Index values as printed; the byte address is four times the index.
    localparam logic [ADDR_W-1:0] IDX_TIMER = 8'h0c;
    localparam logic [ADDR_W-1:0] IDX_HWOPT = 8'h0e;
    localparam logic [ADDR_W-1:0] OFF_TIMER = ADDR_W'(IDX_TIMER * 4);
    localparam logic [ADDR_W-1:0] OFF_HWOPT = ADDR_W'(IDX_HWOPT * 4);
    localparam logic [ADDR_W-1:0] OFF_PINCFG = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_LOCK1 = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h48;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Field positions.
    localparam int ON_LSB = 4;
    localparam int PER_LSB = 0;
    localparam int HYST_BIT = 7;
    localparam int TWAIT_BIT = 5;
    localparam int RDEL_BIT = 4;
    localparam int LOCK0_BIT = 3;
    localparam int PUMP_BIT = 4;
    localparam int WAKE_BIT = 5;
    localparam logic [6:0] TIMER_RST = 7'h00;
    localparam logic [2:0] PIN_RST = 3'h0;
    localparam logic [2:0] ON_OFF_LOW = 3'h0;
    localparam logic [2:0] ON_OFF_HIGH = 3'h6;
    localparam logic [2:0] ON_MAX_RUN = 3'h5;
    localparam logic [2:0] PIN_HS_TIMER = 3'h3;
    // Timing: one timer tick is 0.1 ms, the clock period is 100 ns.
    localparam int TICK_NS = 100000;
    localparam int CLK_NS = 100;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int CNT_W = 24;
    typedef logic [CNT_W-1:0] cth_cnt_t;
    // On-time in ticks of 0.1 ms.
    function automatic cth_cnt_t cth_on_ticks(input logic [2:0] code);
        case (code)
            3'h1: return 24'h000001;
            3'h2: return 24'h000003;
            3'h3: return 24'h00000a;
            3'h4: return 24'h000064;
            3'h5: return 24'h0000c8;
            default: return 24'h000000;
        endcase
    endfunction : cth_on_ticks
    // Period in ticks of 0.1 ms, 10 ms up to 1000 s.
    function automatic cth_cnt_t cth_per_ticks(input logic [3:0] code);
        case (code)
            4'h0: return 24'h000064;
            4'h1: return 24'h0000c8;
            4'h2: return 24'h0001f4;
            4'h3: return 24'h0003e8;
            4'h4: return 24'h0007d0;
            4'h5: return 24'h001388;
            // RULE4 assumed 1 s step.
            4'h6: return 24'h002710;
            4'h7: return 24'h004e20;
            4'h8: return 24'h00c350;
            4'h9: return 24'h0186a0;
            4'ha: return 24'h030d40;
            4'hb: return 24'h07a120;
            4'hc: return 24'h0f4240;
            4'hd: return 24'h1e8480;
            4'he: return 24'h4c4b40;
            default: return 24'h989680;
        endcase
    endfunction : cth_per_ticks
endpackage : cth_pkg

// >>> cth_host.sv
// Host model that drives the register bus of the cyclic timer block.
`timescale 1ns/1ps
`default_nettype none
module cth_host (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // ********************************
    // Bus cycles
    // ********************************
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end
    // Released lines show the inverse, so a slave that samples late sees junk.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        {awvalid, wvalid} <= 2'h3;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && awready === 1'b1) begin
                ta = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!tw && wready === 1'b1) begin
                tw = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~{24'h000000, d};
            end
        end
        // Ready rises only once both halves are taken, so back-to-back writes never drive it twice.
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : cth_host
`default_nettype wire

// >>> cth_top_tb.sv
// Self-checking bench for the cyclic timer and hardware option block.
`timescale 1ns/1ps
`default_nettype none
module cth_top_tb;
    import cth_pkg::*;
    localparam int TK = 2;
    localparam int ON_T[8] = '{0, 1, 3, 10, 100, 200, 0, 0};
    localparam int PER_T[16] = '{100, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000,
        100000, 200000, 500000, 1000000, 2000000, 5000000, 10000000};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic soft_reset = 1'b0;
    logic restart_mode = 1'b0;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic timed_high_side_out, cyclic_wake_tick, uv_release_hyst_sel;
    logic thermal_release_wait_sel, reset_delay_sel, pump_output_enable;
    logic [2:0] pin_config;
    int fail_count = 0;
    int n_tests = 0;
    int wk_n = 0;
    // ********************************
    // Instances and clock
    // ********************************
    cth_host h (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready);
    cth_top #(.TICK_CYCLES(TK)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .soft_reset, .restart_mode,
        .timed_high_side_out, .cyclic_wake_tick, .uv_release_hyst_sel,
        .thermal_release_wait_sel, .reset_delay_sel, .pump_output_enable, .pin_config);
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        if (cyclic_wake_tick === 1'b1) wk_n++;
    end
    // ********************************
    // Checks and helpers
    // ********************************
    function automatic int span(input int code, input bit is_per);
        return (is_per ? PER_T[code] : ON_T[code]) * TK;
    endfunction : span
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wrap_up;
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        h.wr(a, d, r);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        h.rd(a, d, r);
        chk(d, e);
        chk(r, RESP_OKAY);
    endtask : rreg
    // Counts whole cycles at one output level; ends on the edge that leaves it.
    task automatic meas(input logic lvl, output int n);
        n = 0;
        while (timed_high_side_out === lvl && n < 30000) begin
            n++;
            @(posedge aclk);
        end
    endtask : meas
    task automatic pulse_soft;
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        @(posedge aclk);
    endtask : pulse_soft
    initial begin
        #(100000 * 100);
        fail_count++;
        wrap_up();
    end
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        int seed;
        int k;
        int nh;
        int nl;
        int w0;
        logic [2:0] on;
        logic [3:0] per;
        logic [1:0] r;
        logic [31:0] d;
        seed = $urandom(27194);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rreg(OFF_TIMER, 32'h0);
        rreg(OFF_HWOPT, 32'h0);
        h.wr(8'h04, 8'h5a, r);
        chk(r, RESP_SLVERR);
        h.rd(8'h04, d, r);
        chk(d, 32'h0);
        chk(r, RESP_SLVERR);
        h.wr(OFF_PINCFG, 8'h33, r);
        chk(r, RESP_OKAY);
        chk({pump_output_enable, pin_config}, 4'hb);
        wreg(OFF_TIMER, 8'hff);
        rreg(OFF_TIMER, 32'h7f);
        repeat (3) @(posedge aclk);
        chk(timed_high_side_out, 1'b0);
        wreg(OFF_TIMER, 8'h60);
        repeat (3) @(posedge aclk);
        chk(timed_high_side_out, 1'b1);
        wreg(OFF_TIMER, 8'h00);
        repeat (3) @(posedge aclk);
        chk(timed_high_side_out, 1'b0);
        // Rewrites land in the low phase, so a late restart would show up.
        for (int i = 1; i <= 6; i++) begin
            on = (i < 6) ? 3'(i) : 3'h1;
            per = (i < 6) ? 4'(2 + $urandom % 2) : 4'h6;
            wreg(OFF_TIMER, {1'b0, on, per});
            k = 0;
            while (timed_high_side_out !== 1'b1 && k < 4) begin
                k++;
                @(posedge aclk);
            end
            chk(k < 4, 1'b1);
            meas(1'b1, nh);
            chk(nh, span(on, 1'b0));
            w0 = wk_n;
            meas(1'b0, nl);
            chk(nh + nl, span(per, 1'b1));
            meas(1'b1, nh);
            repeat (5) @(posedge aclk);
            chk(wk_n - w0, 1);
        end
        wreg(OFF_HWOPT, 8'hff);
        rreg(OFF_HWOPT, 32'hb8);
        chk(uv_release_hyst_sel, 1'b1);
        chk(thermal_release_wait_sel, 1'b1);
        chk(reset_delay_sel, 1'b1);
        wreg(OFF_PINCFG, 8'h04);
        chk({pump_output_enable, pin_config}, 4'hb);
        restart_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        restart_mode <= 1'b0;
        rreg(OFF_TIMER, 32'h0);
        chk(timed_high_side_out, 1'b0);
        rreg(OFF_HWOPT, 32'hb8);
        pulse_soft();
        rreg(OFF_HWOPT, 32'h08);
        chk({pump_output_enable, pin_config}, 4'hb);
        wreg(OFF_HWOPT, 8'hb8);
        wreg(OFF_LOCK1, 8'h01);
        rreg(OFF_STATUS, 32'h4);
        wreg(OFF_HWOPT, 8'h08);
        rreg(OFF_HWOPT, 32'hb8);
        pulse_soft();
        rreg(OFF_HWOPT, 32'hb8);
        // The level-0 lock stays writable under the level-1 lock.
        wreg(OFF_HWOPT, 8'h00);
        rreg(OFF_HWOPT, 32'hb0);
        wreg(OFF_PINCFG, 8'h00);
        wreg(OFF_TIMER, 8'h52);
        rreg(OFF_STATUS, 32'h4);
        // A write during restart with the timer pin mode dropped must not stick.
        restart_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        wreg(OFF_TIMER, 8'h52);
        rreg(OFF_TIMER, 32'h0);
        chk(timed_high_side_out, 1'b0);
        restart_mode <= 1'b0;
        wreg(OFF_PINCFG, 8'h03);
        wreg(OFF_TIMER, 8'h52);
        rreg(OFF_STATUS, 32'h7);
        wrap_up();
    end
endmodule : cth_top_tb
`default_nettype wire
